// ===== verification/sadc_analog_model.sv
// Behavioural analog front end: fixed level per route, ideal comparator
`timescale 1ns/1ps
module sadc_analog_model #(
  parameter logic [9:0] PIN_LEVEL = 10'h2B5,
  parameter logic [9:0] TEMP_LEVEL = 10'h1C4,
  parameter logic [9:0] FREF_LEVEL = 10'h3F0
) (
  input wire logic [13:0] i_pin_sel,
  input wire logic i_temp_sel,
  input wire logic i_fref_sel,
  input wire logic i_analog_on,
  input wire logic [9:0] i_dac_code,
  output wire logic o_comp_out
);
  wire [9:0] level = i_temp_sel ? TEMP_LEVEL : i_fref_sel ? FREF_LEVEL :
    (|i_pin_sel) ? PIN_LEVEL : 10'h000;
  // keep bit
  // An unpowered core gives no decision, so a trial code never passes
  assign o_comp_out = i_analog_on && (level >= i_dac_code);
endmodule // sadc_analog_model

// ===== verification/sadc_control_assertions.sv
// Port-level checks for the converter control block
`timescale 1ns/1ps
`include "sadc_defs.vh"
module sadc_control_assertions (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  input wire logic i_wb_we,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic o_sample,
  input wire logic [13:0] o_pin_sel,
  input wire logic o_temp_sel,
  input wire logic o_fref_sel,
  input wire logic o_ref_ext,
  input wire logic o_analog_on,
  input wire logic o_irq,
  input wire logic o_wake,
  input wire logic o_vector
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  wire req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire wr0 = i_wb_cyc && i_wb_stb && o_wb_ack && i_wb_we && i_wb_sel[0];
  a_ack_next_cycle: assert property (req |=> o_wb_ack) else $error("ack late");
  a_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
  a_read_upper_zero: assert property (o_wb_ack && !i_wb_we |-> o_wb_dat[31:8] == 24'h0)
    else $error("upper read bits set");
  a_route_single: assert property ($onehot0({o_pin_sel, o_temp_sel, o_fref_sel}))
    else $error("two inputs routed");
  a_temp_route_code: assert property (wr0 && i_wb_adr == `SADC_ADDR_CTRL_A |-> ##2
    o_temp_sel == ($past(i_wb_dat[6:2], 2) == `SADC_CH_TEMP)) else $error("temp route");
  a_ref_follows_write: assert property (wr0 && i_wb_adr == `SADC_ADDR_CTRL_B |-> ##2
    o_ref_ext == $past(i_wb_dat[1], 2)) else $error("reference select");
  a_vector_needs_irq: assert property (o_vector |-> o_irq) else $error("vector alone");
  a_wake_needs_irq: assert property (o_wake |-> o_irq) else $error("wake alone");
  a_sample_powered: assert property (o_sample |-> o_analog_on) else $error("sample unpowered");
  a_reset_quiet: assert property ($rose(i_resetn) |-> !o_analog_on && !o_irq && !o_sample)
    else $error("active after reset");
  c_sample_end: cover property ($fell(o_sample));
  c_vector: cover property (o_vector);
  c_wake: cover property (o_wake);
endmodule // sadc_control_assertions

// ===== verification/sadc_control_tb.sv
// Bench for the converter control block: bus tasks and conversion scenarios
`timescale 1ns/1ps
`include "sadc_defs.vh"
module sadc_control_tb;
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_wb_adr = 8'h00;
  logic [31:0] i_wb_dat = 32'h0;
  logic [3:0] i_wb_sel = 4'h0;
  logic i_wb_we = 1'b0;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_rc_tick = 1'b0;
  wire [31:0] o_wb_dat;
  wire [13:0] o_pin_sel;
  wire [9:0] o_dac_code;
  wire o_wb_ack, i_comp_out, o_sample, o_temp_sel, o_fref_sel, o_ref_ext;
  wire o_analog_on, o_irq, o_wake, o_vector;
  integer n_fail = 0, tests_run = 0, cyc = 0, i, k, t0, m;
  logic [31:0] rd;
  logic [4:0] ch;
  logic [9:0] v = 10'h2B5;
  logic [9:0] vt = 10'h1C4;
  logic [9:0] r;
  logic [2:0] cs_tab [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
  integer half [7] = '{1, 2, 4, 8, 16, 32, 6};
  sadc_control u_sadc_control (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_wb_adr(i_wb_adr),
    .i_wb_dat(i_wb_dat),
    .i_wb_sel(i_wb_sel),
    .i_wb_we(i_wb_we),
    .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb),
    .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack),
    .i_rc_tick(i_rc_tick),
    .i_comp_out(i_comp_out),
    .o_sample(o_sample),
    .o_pin_sel(o_pin_sel),
    .o_temp_sel(o_temp_sel),
    .o_fref_sel(o_fref_sel),
    .o_ref_ext(o_ref_ext),
    .o_analog_on(o_analog_on),
    .o_dac_code(o_dac_code),
    .o_irq(o_irq),
    .o_wake(o_wake),
    .o_vector(o_vector)
  );
  sadc_analog_model u_sadc_analog_model (.i_pin_sel(o_pin_sel), .i_temp_sel(o_temp_sel),
    .i_fref_sel(o_fref_sel), .i_analog_on(o_analog_on), .i_dac_code(o_dac_code),
    .o_comp_out(i_comp_out));
  always #50 i_core_clk = ~i_core_clk;
  // Free-running RC source: half bit period of six core cycles, edges between core edges
  always #300 i_rc_tick = ~i_rc_tick;
  always @(posedge i_core_clk) cyc <= cyc + 1;
  task report_and_stop;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task xfer(input [7:0] a, input w, input [7:0] d);
    integer n;
    @(posedge i_core_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_adr <= a;
    i_wb_we <= w;
    i_wb_dat <= {24'h0, d};
    i_wb_sel <= 4'hF;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    chk("bus ack", 1, o_wb_ack);
    if (o_wb_ack !== 1'b1) report_and_stop;
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we <= 1'b0;
  endtask
  task rdchk(input [7:0] a, input [31:0] exp, input string nm);
    xfer(a, 1'b0, 8'h00);
    chk(nm, exp, rd);
  endtask
  task wait_done;
    // The go write's own read data predates the start, so always poll at least once
    rd = 32'h2;
    for (k = 0; k < 400 && !(rd[1] === 1'b0); k++) xfer(`SADC_ADDR_CTRL_A, 1'b0, 8'h00);
    if (rd[1] !== 1'b0) begin
      chk("conversion end", 0, rd[1]);
      report_and_stop;
    end
  endtask
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    rdchk(`SADC_ADDR_CTRL_A, 0, "ctrl_a reset");
    rdchk(`SADC_ADDR_CTRL_B, 0, "ctrl_b reset");
    rdchk(`SADC_ADDR_FLAGS, 0, "flag reset");
    xfer(8'h20, 1'b1, 8'hFF);
    rdchk(8'h20, 0, "unmapped");
    for (i = 0; i < 17; i++) begin
      ch = (i < 14) ? i[4:0] : (i == 14) ? `SADC_CH_TEMP : (i == 15) ? `SADC_CH_FREF : 5'h0E;
      xfer(`SADC_ADDR_CTRL_A, 1'b1, {1'b0, ch, 2'b01});
      repeat (2) @(posedge i_core_clk);
      chk("pin route", (i < 14) ? (32'h1 << i) : 32'h0, o_pin_sel);
      chk("temp route", ch == `SADC_CH_TEMP, o_temp_sel);
      chk("fref route", ch == `SADC_CH_FREF, o_fref_sel);
    end
    for (i = 0; i < 4; i++) begin
      xfer(`SADC_ADDR_CTRL_B, 1'b1, i[7:0]);
      repeat (2) @(posedge i_core_clk);
      chk("ref select", i >> 1, o_ref_ext);
    end
    xfer(`SADC_ADDR_CTRL_A, 1'b1, 8'h0D);
    repeat (20) @(posedge i_core_clk);
    for (i = 0; i < 7; i++) begin
      xfer(`SADC_ADDR_CTRL_B, 1'b1, {i[0], cs_tab[i], 4'h0});
      xfer(`SADC_ADDR_FLAGS, 1'b1, 8'h00);
      xfer(`SADC_ADDR_CTRL_A, 1'b1, 8'h0F);
      t0 = cyc;
      wait_done;
      m = cyc - t0;
      chk("duration", 1, m >= 22 * half[i] && m <= 23 * half[i] + 20);
      rdchk(`SADC_ADDR_RES_HI, i[0] ? {6'h0, v[9:8]} : v[9:2], "result high");
      rdchk(`SADC_ADDR_RES_LO, i[0] ? v[7:0] : {v[1:0], 6'h0}, "result low");
      rdchk(`SADC_ADDR_FLAGS, 1, "flag set");
      chk("irq masked", 0, o_irq);
    end
    // Temperature channel: settle after routing and between conversions
    xfer(`SADC_ADDR_CTRL_B, 1'b1, 8'h30);
    xfer(`SADC_ADDR_CTRL_A, 1'b1, {1'b0, `SADC_CH_TEMP, 2'b01});
    for (i = 0; i < 2; i++) begin
      repeat (2000) @(posedge i_core_clk);
      xfer(`SADC_ADDR_CTRL_A, 1'b1, {1'b0, `SADC_CH_TEMP, 2'b11});
      wait_done;
      rdchk(`SADC_ADDR_RES_HI, {24'h0, vt[9:2]}, "temp result");
    end
    xfer(`SADC_ADDR_CTRL_A, 1'b1, 8'h0D);
    repeat (20) @(posedge i_core_clk);
    xfer(`SADC_ADDR_ENABLES, 1'b1, 8'h01);
    xfer(`SADC_ADDR_IRQCTL, 1'b1, 8'hC0);
    repeat (2) @(posedge i_core_clk);
    chk("irq", 1, o_irq);
    chk("vector", 1, o_vector);
    xfer(`SADC_ADDR_FLAGS, 1'b1, 8'h01);
    rdchk(`SADC_ADDR_FLAGS, 1, "flag kept");
    xfer(`SADC_ADDR_FLAGS, 1'b1, 8'h00);
    rdchk(`SADC_ADDR_FLAGS, 0, "flag cleared");
    chk("irq cleared", 0, o_irq);
    // Sleep on the RC clock: conversion finishes and wakes without vectoring
    xfer(`SADC_ADDR_IRQCTL, 1'b1, 8'h00);
    xfer(`SADC_ADDR_CTRL_A, 1'b1, 8'h0F);
    xfer(`SADC_ADDR_SLEEP, 1'b1, 8'h01);
    for (k = 0; k < 400 && o_wake !== 1'b1; k++) @(posedge i_core_clk);
    chk("wake", 1, o_wake);
    if (o_wake !== 1'b1) report_and_stop;
    chk("no vector", 0, o_vector);
    rdchk(`SADC_ADDR_SLEEP, 0, "sleep left");
    xfer(`SADC_ADDR_FLAGS, 1'b1, 8'h00);
    // Abort on the slowest divider, a few bits in
    xfer(`SADC_ADDR_CTRL_B, 1'b1, 8'hE0);
    xfer(`SADC_ADDR_CTRL_A, 1'b1, 8'h0F);
    @(posedge i_core_clk);
    chk("sample phase", 1, o_sample);
    repeat (199) @(posedge i_core_clk);
    xfer(`SADC_ADDR_CTRL_A, 1'b1, 8'h0D);
    rdchk(`SADC_ADDR_CTRL_A, 8'h0D, "abort status");
    xfer(`SADC_ADDR_RES_HI, 1'b0, 8'h00);
    r[9:8] = rd[1:0];
    xfer(`SADC_ADDR_RES_LO, 1'b0, 8'h00);
    r[7:0] = rd[7:0];
    m = 0;
    for (k = 1; k < 10; k++)
      if (r === (((v >> (10 - k)) << (10 - k)) | ({10{v[10 - k]}} & ((10'h1 << (10 - k)) - 1))))
        m = 1;
    chk("partial result", 1, m);
    // Reset in mid conversion
    xfer(`SADC_ADDR_CTRL_A, 1'b1, 8'h0F);
    repeat (50) @(posedge i_core_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    rdchk(`SADC_ADDR_CTRL_A, 0, "ctrl_a after reset");
    rdchk(`SADC_ADDR_CTRL_B, 0, "ctrl_b after reset");
    chk("powered off", 0, o_analog_on);
    // Sleep on a divided clock aborts and powers down, enable kept
    xfer(`SADC_ADDR_CTRL_B, 1'b1, 8'h60);
    xfer(`SADC_ADDR_CTRL_A, 1'b1, 8'h0D);
    repeat (20) @(posedge i_core_clk);
    xfer(`SADC_ADDR_CTRL_A, 1'b1, 8'h0F);
    rdchk(`SADC_ADDR_CTRL_A, 8'h0F, "busy before sleep");
    xfer(`SADC_ADDR_SLEEP, 1'b1, 8'h01);
    repeat (2) @(posedge i_core_clk);
    chk("sleep power", 0, o_analog_on);
    rdchk(`SADC_ADDR_CTRL_A, 8'h0D, "enable kept");
    report_and_stop;
  end
endmodule // sadc_control_tb
bind sadc_control sadc_control_assertions u_sadc_control_assertions (
  .i_core_clk(i_core_clk),
  .i_resetn(i_resetn),
  .i_wb_adr(i_wb_adr),
  .i_wb_dat(i_wb_dat),
  .i_wb_sel(i_wb_sel),
  .i_wb_we(i_wb_we),
  .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb),
  .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack),
  .o_sample(o_sample),
  .o_pin_sel(o_pin_sel),
  .o_temp_sel(o_temp_sel),
  .o_fref_sel(o_fref_sel),
  .o_ref_ext(o_ref_ext),
  .o_analog_on(o_analog_on),
  .o_irq(o_irq),
  .o_wake(o_wake),
  .o_vector(o_vector)
);

// ===== verilog/sadc_control.v
// Control logic of a 10-bit successive-approximation converter
// Behaviour
// - one multiplexer channel is reserved for the temperature indicator output.
// - a 10-bit result is built bit by bit and stored in the pair.
// - channel select decides which input reaches the sample-and-hold.
// - reference select chooses external reference pin or supply.
// - three-bit clock select picks divide 2 to 64 or RC clock.
// - one conversion lasts 11.5 bit periods of the chosen clock.
// - divided clocks follow the system clock; RC clock does not.
// - converter runs in sleep only with RC clock selected.
// - interrupt flag sets at every conversion end, enable or not.
// - interrupt request only when flag and enable both set.
// - converter interrupt wakes sleeping device; next instruction runs first.
// - after wake, branch to handler only if global and peripheral enabled.
// - format bit chooses left or right justified result.
// - on completion clear status, set flag, load result.
// - software clear of status aborts, storing partial result padded.
// - RC clock start is delayed one extra instruction cycle.
// - code 11101 is temperature, 11111 fixed reference, 0-13 pins.
`timescale 1ns/1ps
`include "sadc_defs.vh"
module sadc_control #(
  parameter RC_DELAY = `SADC_RC_DELAY_CYC
) (
  input wire i_core_clk,
  input wire i_resetn,
  input wire [7:0] i_wb_adr,
  input wire [31:0] i_wb_dat,
  input wire [3:0] i_wb_sel,
  input wire i_wb_we,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  input wire i_rc_tick,
  input wire i_comp_out,
  output reg o_sample,
  output reg [13:0] o_pin_sel,
  output reg o_temp_sel,
  output reg o_fref_sel,
  output reg o_ref_ext,
  output reg o_analog_on,
  output reg [9:0] o_dac_code,
  output reg o_irq,
  output reg o_wake,
  output reg o_vector
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg converter_enable;
  reg busy;
  reg [4:0] channel_select;
  reg [1:0] positive_ref_select;
  reg [2:0] conversion_clock_select;
  reg result_format;
  reg converter_irq_flag;
  reg converter_irq_enable;
  reg global_irq_enable;
  reg peripheral_irq_enable;
  reg sleeping;
  reg [1:0] rc_sync;
  reg rc_prev;
  reg [5:0] div_cnt;
  reg [4:0] half_cnt;
  reg [9:0] sar;
  reg [3:0] bit_idx;
  reg [3:0] start_dly;
  reg started;
  reg last_bit;
  wire [7:0] res_hi;
  wire [7:0] res_lo;
  reg res_load;
  reg [9:0] res_val;
  wire wb_req;
  wire wr;
  wire use_rc;
  reg [5:0] div_max;
  reg tick;
  assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  // Writes land on the acknowledge edge, while the master still holds the request
  assign wr = i_wb_cyc & i_wb_stb & o_wb_ack & i_wb_we & i_wb_sel[0];
  assign use_rc = (conversion_clock_select[1:0] == `SADC_CS_RC_LOW);
  // ----------------------------------------
  // Bit-period tick
  // ----------------------------------------
  // divisor decode
  always @* begin
    case (conversion_clock_select)
      3'h0: div_max = 6'h00;
      3'h4: div_max = 6'h01;
      3'h1: div_max = 6'h03;
      3'h5: div_max = 6'h07;
      3'h2: div_max = 6'h0F;
      3'h6: div_max = 6'h1F;
      default: div_max = 6'h00;
    endcase
  end
  // Tick marks half a bit period, giving the 11.5 period granularity
  always @* begin
    if (use_rc) begin
      tick = rc_sync[1] & ~rc_prev;
    end else begin
      tick = (div_cnt == div_max);
    end
  end
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rc_sync <= 2'h0;
      rc_prev <= 1'b0;
      div_cnt <= 6'h00;
    end else begin
      rc_sync <= {rc_sync[0], i_rc_tick};
      rc_prev <= rc_sync[1];
      if (!busy || tick) begin
        div_cnt <= 6'h00;
      end else begin
        div_cnt <= div_cnt + 6'h01;
      end
    end
  end
  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy <= 1'b0;
      started <= 1'b0;
      start_dly <= 4'h0;
      half_cnt <= 5'h00;
      sar <= 10'h000;
      bit_idx <= 4'h0;
      last_bit <= 1'b0;
      res_load <= 1'b0;
      res_val <= 10'h000;
      converter_irq_flag <= 1'b0;
      o_sample <= 1'b0;
      o_dac_code <= 10'h000;
    end else begin
      res_load <= 1'b0;
      if (!busy) begin
        o_sample <= 1'b0;
        if (wr && i_wb_adr == `SADC_ADDR_CTRL_A && i_wb_dat[`SADC_A_GO] && converter_enable
            && (!sleeping || use_rc)) begin
          busy <= 1'b1;
          started <= 1'b0;
          start_dly <= use_rc ? RC_DELAY[3:0] : 4'h0;
          half_cnt <= 5'h00;
          sar <= 10'h200;
          bit_idx <= 4'h9;
          last_bit <= 1'b0;
          o_sample <= 1'b1;
          o_dac_code <= 10'h200;
        end
      end else if ((wr && i_wb_adr == `SADC_ADDR_CTRL_A && !i_wb_dat[`SADC_A_GO])
                   || (sleeping && !use_rc) || !converter_enable) begin
        busy <= 1'b0;
        o_sample <= 1'b0;
        if (wr && i_wb_adr == `SADC_ADDR_CTRL_A) begin
          res_load <= 1'b1;
          // All bits decided: nothing left to pad
          if (bit_idx == 4'hF) begin
            res_val <= sar;
          end else begin
            res_val <= sar & ~((10'h001 << bit_idx) - 10'h001) & ~(10'h001 << bit_idx)
                       | ({10{last_bit}} & ((10'h001 << (bit_idx + 4'h1)) - 10'h001));
          end
        end
      end else if (start_dly != 4'h0) begin
        start_dly <= start_dly - 4'h1;
      end else if (tick) begin
        half_cnt <= half_cnt + 5'h01;
        o_sample <= 1'b0;
        if (half_cnt[0] && half_cnt != 5'h01 && bit_idx != 4'hF) begin
          if (!i_comp_out) begin
            sar[bit_idx] <= 1'b0;
            last_bit <= 1'b0;
          end else begin
            last_bit <= 1'b1;
          end
          if (bit_idx != 4'h0) begin
            sar[bit_idx - 4'h1] <= 1'b1;
            o_dac_code <= (i_comp_out ? sar : sar & ~(10'h001 << bit_idx))
                          | (10'h001 << (bit_idx - 4'h1));
          end
          bit_idx <= bit_idx - 4'h1;
        end
        if (half_cnt == `SADC_BIT_PERIODS_X2 - 5'h01) begin
          busy <= 1'b0;
          res_load <= 1'b1;
          res_val <= sar;
        end
      end
      if (busy && tick && start_dly == 4'h0 && half_cnt == `SADC_BIT_PERIODS_X2 - 5'h01
          && converter_enable && !(sleeping && !use_rc)
          && !(wr && i_wb_adr == `SADC_ADDR_CTRL_A && !i_wb_dat[`SADC_A_GO])) begin
        converter_irq_flag <= 1'b1;
      end else if (wr && i_wb_adr == `SADC_ADDR_FLAGS) begin
        converter_irq_flag <= i_wb_dat[0] & converter_irq_flag;
      end
    end
  end
  sadc_result_reg u_result (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_load(res_load),
    .i_value(res_val),
    .i_fmt_right(result_format),
    .o_high(res_hi),
    .o_low(res_lo)
  );
  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      converter_enable <= 1'b0;
      channel_select <= 5'h00;
      positive_ref_select <= 2'h0;
      conversion_clock_select <= 3'h0;
      result_format <= 1'b0;
      converter_irq_enable <= 1'b0;
      global_irq_enable <= 1'b0;
      peripheral_irq_enable <= 1'b0;
      sleeping <= 1'b0;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= wb_req;
      if (wr) begin
        if (i_wb_adr == `SADC_ADDR_CTRL_A) begin
          converter_enable <= i_wb_dat[`SADC_A_ON];
          channel_select <= i_wb_dat[`SADC_A_CHS_HI:`SADC_A_CHS_LO];
        end else if (i_wb_adr == `SADC_ADDR_CTRL_B) begin
          positive_ref_select <= i_wb_dat[`SADC_B_PREF_HI:`SADC_B_PREF_LO];
          conversion_clock_select <= i_wb_dat[`SADC_B_CS_HI:`SADC_B_CS_LO];
          result_format <= i_wb_dat[`SADC_B_FMT];
        end else if (i_wb_adr == `SADC_ADDR_ENABLES) begin
          converter_irq_enable <= i_wb_dat[0];
        end else if (i_wb_adr == `SADC_ADDR_IRQCTL) begin
          global_irq_enable <= i_wb_dat[`SADC_IRQ_GIE];
          peripheral_irq_enable <= i_wb_dat[`SADC_IRQ_PERIPHERAL_IRQ_ENABLE];
        end else if (i_wb_adr == `SADC_ADDR_SLEEP) begin
          sleeping <= i_wb_dat[0];
        end
      end
      if (sleeping && converter_irq_flag && converter_irq_enable) begin
        sleeping <= 1'b0;
      end
      if (i_wb_adr == `SADC_ADDR_CTRL_A) begin
        o_wb_dat <= {24'h000000, 1'b0, channel_select, busy, converter_enable};
      end else if (i_wb_adr == `SADC_ADDR_CTRL_B) begin
        o_wb_dat <= {24'h000000, result_format, conversion_clock_select, 2'h0,
                     positive_ref_select};
      end else if (i_wb_adr == `SADC_ADDR_RES_HI) begin
        o_wb_dat <= {24'h000000, res_hi};
      end else if (i_wb_adr == `SADC_ADDR_RES_LO) begin
        o_wb_dat <= {24'h000000, res_lo};
      end else if (i_wb_adr == `SADC_ADDR_FLAGS) begin
        o_wb_dat <= {31'h00000000, converter_irq_flag};
      end else if (i_wb_adr == `SADC_ADDR_ENABLES) begin
        o_wb_dat <= {31'h00000000, converter_irq_enable};
      end else if (i_wb_adr == `SADC_ADDR_IRQCTL) begin
        o_wb_dat <= {24'h000000, global_irq_enable, peripheral_irq_enable, 6'h00};
      end else if (i_wb_adr == `SADC_ADDR_SLEEP) begin
        o_wb_dat <= {31'h00000000, sleeping};
      end else begin
        o_wb_dat <= 32'h00000000;
      end
    end
  end
  // ----------------------------------------
  // Analog side and interrupt outputs
  // ----------------------------------------
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pin_sel <= 14'h0000;
      o_temp_sel <= 1'b0;
      o_fref_sel <= 1'b0;
      o_ref_ext <= 1'b0;
      o_analog_on <= 1'b0;
      o_irq <= 1'b0;
      o_wake <= 1'b0;
      o_vector <= 1'b0;
    end else begin
      o_pin_sel <= (channel_select <= `SADC_CH_PIN_MAX) ? (14'h0001 << channel_select) : 14'h0000;
      o_temp_sel <= (channel_select == `SADC_CH_TEMP);
      o_fref_sel <= (channel_select == `SADC_CH_FREF);
      o_ref_ext <= positive_ref_select[1];
      o_analog_on <= converter_enable && (!sleeping || (use_rc && busy));
      o_irq <= converter_irq_flag & converter_irq_enable;
      o_wake <= sleeping & converter_irq_flag & converter_irq_enable;
      o_vector <= converter_irq_flag & converter_irq_enable & global_irq_enable
                  & peripheral_irq_enable;
    end
  end
endmodule // sadc_control

// ===== verilog/sadc_defs.vh
// Constants for the successive-approximation converter control block
`ifndef SADC_DEFS_VH
`define SADC_DEFS_VH
// ----------------------------------------
// Register word addresses (byte address)
// ----------------------------------------
`define SADC_ADDR_CTRL_A 8'h00
`define SADC_ADDR_CTRL_B 8'h04
`define SADC_ADDR_RES_HI 8'h08
`define SADC_ADDR_RES_LO 8'h0C
`define SADC_ADDR_FLAGS 8'h10
`define SADC_ADDR_ENABLES 8'h14
`define SADC_ADDR_IRQCTL 8'h18
`define SADC_ADDR_SLEEP 8'h1C
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SADC_A_ON 0
`define SADC_A_GO 1
`define SADC_A_CHS_LO 2
`define SADC_A_CHS_HI 6
`define SADC_B_PREF_LO 0
`define SADC_B_PREF_HI 1
`define SADC_B_CS_LO 4
`define SADC_B_CS_HI 6
`define SADC_B_FMT 7
`define SADC_IRQ_GIE 7
`define SADC_IRQ_PERIPHERAL_IRQ_ENABLE 6
// ----------------------------------------
// Channel codes and clock select codes
// ----------------------------------------
`define SADC_CH_PIN_MAX 5'h0D
`define SADC_CH_TEMP 5'h1D
`define SADC_CH_FREF 5'h1F
`define SADC_CS_RC_LOW 2'h3
// ----------------------------------------
// Sequencing constants
// ----------------------------------------
`define SADC_RES_BITS 10
`define SADC_BIT_PERIODS_X2 5'h17
`define SADC_DIV_W 6
`define SADC_RC_DELAY_CYC 4'h4
`endif

// ===== verilog/sadc_result_reg.v
// Result register pair with left or right justification
`timescale 1ns/1ps
module sadc_result_reg (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_load,
  input wire [9:0] i_value,
  input wire i_fmt_right,
  output reg [7:0] o_high,
  output reg [7:0] o_low
);
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_high <= 8'h00;
      o_low <= 8'h00;
    end else if (i_load) begin
      if (i_fmt_right) begin
        o_high <= {6'h00, i_value[9:8]};
        o_low <= i_value[7:0];
      end else begin
        o_high <= i_value[9:2];
        o_low <= {i_value[1:0], 6'h00};
      end
    end
  end
endmodule // sadc_result_reg
